/* File: reflect_cfg_pkg.sv */
// Constants shared by the reflectometry test controller and its testbench.
// Assumes a 10 MHz core clock and a classic Wishbone master with 32-bit data.
package reflect_cfg_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_GENERAL_A  = 10'h180;
  localparam logic [9:0] IDX_SILENCE    = 10'h181;
  localparam logic [9:0] IDX_LEN_LOW    = 10'h182;
  localparam logic [9:0] IDX_LEN_HIGH   = 10'h183;
  localparam logic [9:0] IDX_WAIT_LOW   = 10'h184;
  localparam logic [9:0] IDX_PULSE_SRCH = 10'h185;
  localparam logic [9:0] IDX_CONTROL    = 10'h186;
  localparam logic [9:0] IDX_STATUS     = 10'h187;

  // Reset values
  localparam logic [15:0] RST_GENERAL_A  = 16'h0752;
  localparam logic [15:0] RST_SILENCE    = 16'hc850;
  localparam logic [15:0] RST_LEN_LOW    = 16'h5326;
  localparam logic [15:0] RST_LEN_HIGH   = 16'ha01e;
  localparam logic [15:0] RST_WAIT_LOW   = 16'he976;
  localparam logic [15:0] RST_PULSE_SRCH = 16'h19cf;

  // Writable bits; everything else is reserved and reads zero
  localparam logic [15:0] WM_GENERAL_A  = 16'h1fff;
  localparam logic [15:0] WM_SILENCE    = 16'hfff0;
  localparam logic [15:0] WM_LEN_LOW    = 16'h7fff;
  localparam logic [15:0] WM_LEN_HIGH   = 16'hff3f;
  localparam logic [15:0] WM_WAIT_LOW   = 16'hff77;
  localparam logic [15:0] WM_PULSE_SRCH = 16'h39ff;

  // Field positions
  localparam int SKIP_BIT   = 12;
  localparam int XLIST_BIT  = 11;
  localparam int LPCHK_BIT  = 10;
  localparam int AVG_LSB    = 7;
  localparam int SEGN_LSB   = 4;
  localparam int CYCT_LSB   = 0;
  localparam int THR_LSB    = 8;
  localparam int POSTQ_LSB  = 6;
  localparam int PREQ_LSB   = 4;
  localparam int SEG1_LSB   = 0;
  localparam int SEG2_LSB   = 5;
  localparam int SEG3_LSB   = 10;
  localparam int SEG4_LSB   = 0;
  localparam int SEG5_LSB   = 8;
  localparam int WAIT1_LSB  = 0;
  localparam int WAIT2_LSB  = 4;
  localparam int WAIT3_LSB  = 8;
  localparam int WAIT4_LSB  = 12;
  localparam int WAIT5_LSB  = 0;
  localparam int PTYPE_LSB  = 4;
  localparam int SPAN_LSB   = 11;
  localparam int START_BIT  = 0;

  localparam logic [2:0] AVG_RESERVED = 3'h7;
  localparam logic [2:0] AVG_MAX      = 3'h6;
  localparam logic [2:0] SEG_MAX      = 3'h5;

  // Timing
  localparam int CLK_HZ         = 10_000_000;
  localparam int US_PER_UNIT    = 1;
  localparam int CYCLES_PER_US  = CLK_HZ / 1_000_000;
  localparam int QUIET_UNIT_US  = 1;
  localparam int QUIET_UNIT_CYC = (QUIET_UNIT_US * CLK_HZ + 999_999) / 1_000_000;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_PRE   = 7'h02,
    ST_SEG   = 7'h04,
    ST_PEAK  = 7'h08,
    ST_REST  = 7'h10,
    ST_POST  = 7'h20,
    ST_DONE  = 7'h40
  } test_state_e;
endpackage

/* File: interval_timer.sv */
// Down-counting interval timer used for the silence, segment and peak-wait phases of a test.
// Assumes the caller loads length minus one and waits for expired_o.
module interval_timer #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] value_i,
  output logic                  expired_o
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  always_comb begin
    next_count = count;
    if (load_i) begin
      next_count = value_i;
    end else if (count != '0) begin
      next_count = count - WIDTH'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign expired_o = (count == '0);
endmodule

/* File: reflect_test_ctrl.sv */
// Cable reflectometry test configuration registers and test sequencer.
// Assumes a classic Wishbone master, synchronous line energy and link pulse inputs.
//
// Our own choice: the Wishbone register port.

// Notes on behaviour
// - Skip bit set: test only pairs one and two, omit pairs three and four
// - Cross-listen disable: listen only on the pair being driven
// - Link-pulse check (default on): link pulses during silence fail the test
// - Averaging runs two to the field power cycles; reserved code acts as 64
// - Segment count field gives segments per cycle, five by default
// - Each reflectometry cycle lasts the cycle time field in microseconds, or one clock past its segments when they run longer
// - Pre-silence energy above the threshold field fails the test
// - Any energy during post-silence fails the test
// - Segments one to three last their five-bit duration fields in clocks
// - Segment four uses six-bit, segment five eight-bit duration field
// - Each segment waits its own peak-wait field after the maximum
// - Each segment drives its own selected pulse type
// - Averaged peak search span comes from the average-location field
module reflect_test_ctrl (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [11:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic [7:0]  line_energy_i,
  input  wire logic        link_pulse_i,
  output logic             tx_active_o,
  output logic             pulse_type_o,
  output logic      [1:0]  tx_pair_o,
  output logic      [3:0]  listen_mask_o,
  output logic      [2:0]  segment_o,
  output logic      [3:0]  peak_wait_o,
  output logic      [2:0]  peak_span_o,
  output logic             test_busy_o,
  output logic             test_fail_o
);
  // Register file
  logic [15:0] gen_a, silence, len_low, len_high, wait_low, pulse_srch;
  logic [15:0] next_gen_a, next_silence, next_len_low, next_len_high;
  logic [15:0] next_wait_low, next_pulse_srch;
  logic        next_ack;
  logic [31:0] next_dat;
  logic        start_req;
  logic [9:0]  idx;

  function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [31:0] wd,
                                        input logic [3:0] sel, input logic [15:0] wmask);
    logic [15:0] lane;
    lane = {{8{sel[1]}}, {8{sel[0]}}} & wmask;
    merge = (old_v & ~lane) | (wd[15:0] & lane);
  endfunction

  // Sequencer state
  reflect_cfg_pkg::test_state_e state, next_state;
  logic [1:0]  pair, next_pair, last_pair;
  logic [6:0]  avg_cnt, next_avg_cnt, avg_last;
  logic [2:0]  seg, next_seg, seg_last;
  logic [15:0] cyc_cnt, next_cyc_cnt, cyc_len;
  logic        skip, next_skip;
  logic        fail, next_fail;
  logic        done, next_done;
  logic        tmr_load;
  logic [15:0] tmr_value;
  logic        tmr_expired;
  logic        next_tx_active, next_pulse_type;
  logic [1:0]  next_tx_pair;
  logic [3:0]  next_listen, next_peak_wait;
  logic [2:0]  next_segment, next_span;
  logic        quiet_pulse;

  function automatic logic [15:0] seg_len(input logic [2:0] s, input logic [15:0] lo,
                                          input logic [15:0] hi);
    logic [7:0] n;
    case (s)
      3'h1: n = {3'h0, lo[reflect_cfg_pkg::SEG1_LSB +: 5]};
      3'h2: n = {3'h0, lo[reflect_cfg_pkg::SEG2_LSB +: 5]};
      3'h3: n = {3'h0, lo[reflect_cfg_pkg::SEG3_LSB +: 5]};
      3'h4: n = {2'h0, hi[reflect_cfg_pkg::SEG4_LSB +: 6]};
      default: n = hi[reflect_cfg_pkg::SEG5_LSB +: 8];
    endcase
    // A zero length still takes one clock
    seg_len = (n == 8'h00) ? 16'h0000 : {8'h00, n - 8'h01};
  endfunction

  function automatic logic [3:0] seg_wait(input logic [2:0] s, input logic [15:0] w,
                                          input logic [15:0] p);
    case (s)
      3'h1: seg_wait = {1'b0, w[reflect_cfg_pkg::WAIT1_LSB +: 3]};
      3'h2: seg_wait = {1'b0, w[reflect_cfg_pkg::WAIT2_LSB +: 3]};
      3'h3: seg_wait = w[reflect_cfg_pkg::WAIT3_LSB +: 4];
      3'h4: seg_wait = w[reflect_cfg_pkg::WAIT4_LSB +: 4];
      default: seg_wait = p[reflect_cfg_pkg::WAIT5_LSB +: 4];
    endcase
  endfunction

  function automatic logic [15:0] quiet_len(input logic [1:0] f);
    logic [15:0] n;
    n = 16'(f) * 16'(reflect_cfg_pkg::QUIET_UNIT_CYC);
    quiet_len = (n == 16'h0000) ? 16'h0000 : n - 16'h0001;
  endfunction

  assign idx = adr_i[11:2];
  assign start_req = cyc_i && stb_i && we_i && !ack_o && sel_i[0]
                     && (idx == reflect_cfg_pkg::IDX_CONTROL)
                     && dat_i[reflect_cfg_pkg::START_BIT];

  // Bus slave: one wait state, ack for one cycle, unmapped reads give zero
  always_comb begin
    next_gen_a      = gen_a;
    next_silence    = silence;
    next_len_low    = len_low;
    next_len_high   = len_high;
    next_wait_low   = wait_low;
    next_pulse_srch = pulse_srch;
    next_ack        = cyc_i && stb_i && !ack_o;
    next_dat        = 32'h0000_0000;
    if (cyc_i && stb_i && !ack_o) begin
      if (we_i) begin
        if (idx == reflect_cfg_pkg::IDX_GENERAL_A) begin
          next_gen_a = merge(gen_a, dat_i, sel_i, reflect_cfg_pkg::WM_GENERAL_A);
        end else if (idx == reflect_cfg_pkg::IDX_SILENCE) begin
          next_silence = merge(silence, dat_i, sel_i, reflect_cfg_pkg::WM_SILENCE);
        end else if (idx == reflect_cfg_pkg::IDX_LEN_LOW) begin
          next_len_low = merge(len_low, dat_i, sel_i, reflect_cfg_pkg::WM_LEN_LOW);
        end else if (idx == reflect_cfg_pkg::IDX_LEN_HIGH) begin
          next_len_high = merge(len_high, dat_i, sel_i, reflect_cfg_pkg::WM_LEN_HIGH);
        end else if (idx == reflect_cfg_pkg::IDX_WAIT_LOW) begin
          next_wait_low = merge(wait_low, dat_i, sel_i, reflect_cfg_pkg::WM_WAIT_LOW);
        end else if (idx == reflect_cfg_pkg::IDX_PULSE_SRCH) begin
          next_pulse_srch = merge(pulse_srch, dat_i, sel_i,
                                  reflect_cfg_pkg::WM_PULSE_SRCH);
        end
      end else begin
        if (idx == reflect_cfg_pkg::IDX_GENERAL_A) begin
          next_dat = {16'h0000, gen_a};
        end else if (idx == reflect_cfg_pkg::IDX_SILENCE) begin
          next_dat = {16'h0000, silence};
        end else if (idx == reflect_cfg_pkg::IDX_LEN_LOW) begin
          next_dat = {16'h0000, len_low};
        end else if (idx == reflect_cfg_pkg::IDX_LEN_HIGH) begin
          next_dat = {16'h0000, len_high};
        end else if (idx == reflect_cfg_pkg::IDX_WAIT_LOW) begin
          next_dat = {16'h0000, wait_low};
        end else if (idx == reflect_cfg_pkg::IDX_PULSE_SRCH) begin
          next_dat = {16'h0000, pulse_srch};
        end else if (idx == reflect_cfg_pkg::IDX_STATUS) begin
          next_dat = {24'h00_0000, seg, pair, done, fail, test_busy_o};
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gen_a      <= reflect_cfg_pkg::RST_GENERAL_A;
      silence    <= reflect_cfg_pkg::RST_SILENCE;
      len_low    <= reflect_cfg_pkg::RST_LEN_LOW;
      len_high   <= reflect_cfg_pkg::RST_LEN_HIGH;
      wait_low   <= reflect_cfg_pkg::RST_WAIT_LOW;
      pulse_srch <= reflect_cfg_pkg::RST_PULSE_SRCH;
      ack_o      <= 1'b0;
      dat_o      <= 32'h0000_0000;
    end else begin
      gen_a      <= next_gen_a;
      silence    <= next_silence;
      len_low    <= next_len_low;
      len_high   <= next_len_high;
      wait_low   <= next_wait_low;
      pulse_srch <= next_pulse_srch;
      ack_o      <= next_ack;
      dat_o      <= next_dat;
    end
  end

  // Settings are read live, so a change mid-test takes effect at the next phase;
  // only the pair skip is latched so the pair walk cannot jump past its end.
  always_comb begin
    logic [2:0] avg_code;
    avg_code = gen_a[reflect_cfg_pkg::AVG_LSB +: 3];
    if (avg_code == reflect_cfg_pkg::AVG_RESERVED) begin
      avg_code = reflect_cfg_pkg::AVG_MAX;
    end
    avg_last = 7'((7'h01 << avg_code) - 7'h01);
    seg_last = gen_a[reflect_cfg_pkg::SEGN_LSB +: 3];
    if (seg_last > reflect_cfg_pkg::SEG_MAX) begin
      seg_last = reflect_cfg_pkg::SEG_MAX;
    end
    cyc_len = 16'(gen_a[reflect_cfg_pkg::CYCT_LSB +: 4])
              * 16'(reflect_cfg_pkg::CYCLES_PER_US * reflect_cfg_pkg::US_PER_UNIT);
    last_pair = skip ? 2'h1 : 2'h3;
  end

  assign quiet_pulse = gen_a[reflect_cfg_pkg::LPCHK_BIT] && link_pulse_i;

  always_comb begin
    next_state   = state;
    next_pair    = pair;
    next_avg_cnt = avg_cnt;
    next_seg     = seg;
    next_cyc_cnt = cyc_cnt + 16'h0001;
    next_skip    = skip;
    next_fail    = fail;
    next_done    = done;
    tmr_load     = 1'b0;
    tmr_value    = 16'h0000;
    case (state)
      reflect_cfg_pkg::ST_IDLE, reflect_cfg_pkg::ST_DONE: begin
        next_cyc_cnt = 16'h0000;
        if (start_req) begin
          next_state = reflect_cfg_pkg::ST_PRE;
          next_skip  = gen_a[reflect_cfg_pkg::SKIP_BIT];
          next_pair  = 2'h0;
          next_fail  = 1'b0;
          next_done  = 1'b0;
          tmr_load   = 1'b1;
          tmr_value  = quiet_len(silence[reflect_cfg_pkg::PREQ_LSB +: 2]);
        end
      end
      reflect_cfg_pkg::ST_PRE: begin
        if (line_energy_i > silence[reflect_cfg_pkg::THR_LSB +: 8] || quiet_pulse) begin
          next_fail = 1'b1;
        end
        if (tmr_expired) begin
          next_state   = (seg_last == 3'h0) ? reflect_cfg_pkg::ST_REST : reflect_cfg_pkg::ST_SEG;
          next_seg     = 3'h1;
          next_avg_cnt = 7'h00;
          next_cyc_cnt = 16'h0000;
          tmr_load     = 1'b1;
          tmr_value    = seg_len(3'h1, len_low, len_high);
        end
      end
      reflect_cfg_pkg::ST_SEG: begin
        if (tmr_expired) begin
          next_state = reflect_cfg_pkg::ST_PEAK;
          tmr_load   = 1'b1;
          tmr_value  = 16'(seg_wait(seg, wait_low, pulse_srch));
        end
      end
      reflect_cfg_pkg::ST_PEAK: begin
        if (tmr_expired) begin
          if (seg >= seg_last) begin
            next_state = reflect_cfg_pkg::ST_REST;
          end else begin
            next_state = reflect_cfg_pkg::ST_SEG;
            next_seg   = seg + 3'h1;
            tmr_load   = 1'b1;
            tmr_value  = seg_len(seg + 3'h1, len_low, len_high);
          end
        end
      end
      reflect_cfg_pkg::ST_REST: begin
        if (next_cyc_cnt >= cyc_len) begin
          next_cyc_cnt = 16'h0000;
          next_seg     = 3'h1;
          tmr_load     = 1'b1;
          tmr_value    = seg_len(3'h1, len_low, len_high);
          next_state   = (seg_last == 3'h0) ? reflect_cfg_pkg::ST_REST : reflect_cfg_pkg::ST_SEG;
          if (avg_cnt < avg_last) begin
            next_avg_cnt = avg_cnt + 7'h01;
          end else if (pair < last_pair) begin
            next_avg_cnt = 7'h00;
            next_pair    = pair + 2'h1;
          end else begin
            next_state = reflect_cfg_pkg::ST_POST;
            tmr_value  = quiet_len(silence[reflect_cfg_pkg::POSTQ_LSB +: 2]);
          end
        end
      end
      reflect_cfg_pkg::ST_POST: begin
        if (line_energy_i != 8'h00 || quiet_pulse) begin
          next_fail = 1'b1;
        end
        if (tmr_expired) begin
          next_state = reflect_cfg_pkg::ST_DONE;
          next_done  = 1'b1;
        end
      end
      default: begin
        next_state = reflect_cfg_pkg::ST_IDLE;
      end
    endcase
  end

  interval_timer #(
    .WIDTH(16)
  ) u_timer (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .load_i   (tmr_load),
    .value_i  (tmr_value),
    .expired_o(tmr_expired)
  );

  // Line-side controls, registered so every output leaves a flip-flop
  always_comb begin
    next_tx_active  = (next_state == reflect_cfg_pkg::ST_SEG);
    next_tx_pair    = next_pair;
    next_segment    = (next_tx_active || next_state == reflect_cfg_pkg::ST_PEAK)
                      ? next_seg : 3'h0;
    next_pulse_type = pulse_srch[reflect_cfg_pkg::PTYPE_LSB + 32'(next_seg) - 1];
    next_peak_wait  = seg_wait(next_seg, wait_low, pulse_srch);
    next_span       = pulse_srch[reflect_cfg_pkg::SPAN_LSB +: 3];
    if (gen_a[reflect_cfg_pkg::XLIST_BIT]) begin
      next_listen = 4'h1 << next_pair;
    end else begin
      next_listen = next_skip ? 4'h3 : 4'hf;
    end
    if (next_segment == 3'h0) begin
      next_listen     = 4'h0;
      next_pulse_type = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state         <= reflect_cfg_pkg::ST_IDLE;
      pair          <= 2'h0;
      avg_cnt       <= 7'h00;
      seg           <= 3'h0;
      cyc_cnt       <= 16'h0000;
      skip          <= 1'b0;
      fail          <= 1'b0;
      done          <= 1'b0;
      tx_active_o   <= 1'b0;
      pulse_type_o  <= 1'b0;
      tx_pair_o     <= 2'h0;
      listen_mask_o <= 4'h0;
      segment_o     <= 3'h0;
      peak_wait_o   <= 4'h0;
      peak_span_o   <= 3'h0;
      test_busy_o   <= 1'b0;
      test_fail_o   <= 1'b0;
    end else begin
      state         <= next_state;
      pair          <= next_pair;
      avg_cnt       <= next_avg_cnt;
      seg           <= next_seg;
      cyc_cnt       <= next_cyc_cnt;
      skip          <= next_skip;
      fail          <= next_fail;
      done          <= next_done;
      tx_active_o   <= next_tx_active;
      pulse_type_o  <= next_pulse_type;
      tx_pair_o     <= next_tx_pair;
      listen_mask_o <= next_listen;
      segment_o     <= next_segment;
      peak_wait_o   <= next_peak_wait;
      peak_span_o   <= next_span;
      test_busy_o   <= (next_state != reflect_cfg_pkg::ST_IDLE)
                       && (next_state != reflect_cfg_pkg::ST_DONE);
      test_fail_o   <= next_fail;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_skip_pairs_only: assert property ((test_busy_o && skip) |-> tx_pair_o < 2'h2)
    else $error("pair three or four used while skipped");
  a_listen_same_pair: assert property (
    (tx_active_o && gen_a[reflect_cfg_pkg::XLIST_BIT] && $stable(gen_a))
      |-> listen_mask_o == (4'h1 << tx_pair_o))
    else $error("listening off the driven pair");
  a_pre_pulse_fails: assert property (
    (state == reflect_cfg_pkg::ST_PRE && quiet_pulse) |=> test_fail_o)
    else $error("link pulse in silence did not fail");
  a_average_bound: assert property (avg_cnt <= 7'd63)
    else $error("averaging count beyond 64 cycles");
  a_segment_bound: assert property (segment_o <= reflect_cfg_pkg::SEG_MAX)
    else $error("segment index beyond five");
  // Long segment sets may overrun the cycle; the rest phase then lasts one clock
  a_cycle_length: assert property (
    (state == reflect_cfg_pkg::ST_REST && cyc_cnt + 16'h0001 >= cyc_len)
      |=> cyc_cnt == 16'h0000)
    else $error("cycle ran past its length");
  a_pre_energy_fails: assert property (
    (state == reflect_cfg_pkg::ST_PRE
      && line_energy_i > silence[reflect_cfg_pkg::THR_LSB +: 8]) |=> fail ##1 test_fail_o)
    else $error("pre-silence energy did not fail");
  a_post_energy_fails: assert property (
    (state == reflect_cfg_pkg::ST_POST && line_energy_i != 8'h00) |=> fail)
    else $error("post-silence energy did not fail");
  a_seg_one_start: assert property (
    (state == reflect_cfg_pkg::ST_PRE && tmr_expired && seg_last != 3'h0)
      |=> state == reflect_cfg_pkg::ST_SEG && seg == 3'h1)
    else $error("segment one did not follow pre-silence");
  a_reserved_zero: assert property (
    (ack_o && !we_i && idx == reflect_cfg_pkg::IDX_GENERAL_A) |-> dat_o[31:13] == '0)
    else $error("reserved bits read non-zero");
endmodule

/* File: cable_echo_model.sv */
// Line model: energy level and link pulses seen on the pair inputs.
// Assumes the bench arms it before each test. It goes quiet once driving starts unless kept.
module cable_echo_model (
  input  wire logic       clk_i,
  input  wire logic       arm_i,
  input  wire logic       tx_active_i,
  input  wire logic       keep_i,
  input  wire logic [7:0] level_i,
  input  wire logic       pulse_i,
  output logic      [7:0] energy_o,
  output logic            pulse_o
);
  logic seen;
  logic next_seen;
  always_comb begin
    next_seen = arm_i ? 1'b0 : (seen | tx_active_i);
  end
  // Registered outputs, so the line goes quiet one clock after driving starts
  always_ff @(posedge clk_i) begin
    seen     <= next_seen;
    energy_o <= (next_seen && !keep_i) ? 8'h00 : level_i;
    pulse_o  <= (next_seen && !keep_i) ? 1'b0 : pulse_i;
  end
endmodule

/* File: cable_reflectometry_test_config_test.sv */
// Self-checking bench for the reflectometry configuration and sequencer.
// Assumes a 10 MHz clock and the line model in cable_echo_model.
module cable_reflectometry_test_config_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i, rst_i, cyc, stb, we, ack_o, arm, keep, pls, link_pulse;
  logic        tx_active_o, pulse_type_o, test_busy_o, test_fail_o, sk, xd;
  logic [11:0] adr;
  logic [3:0]  sel, listen_mask_o, peak_wait_o;
  logic [31:0] wdat, dat_o;
  logic [7:0]  lvl, energy;
  logic [1:0]  tx_pair_o, maxp;
  logic [2:0]  segment_o, peak_span_o;
  logic [5:0]  segs;
  logic        ptype [6];
  logic [3:0]  pwait [6];
  int          err_total, n_checks, bad, txc [6], starts [$];
  logic [15:0] rstv [6] = '{16'h0752, 16'hc850, 16'h5326, 16'ha01e, 16'he976, 16'h19cf};
  logic [15:0] wmv [6] = '{16'h1fff, 16'hfff0, 16'h7fff, 16'hff3f, 16'hff77, 16'h39ff};

  reflect_test_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
    .line_energy_i(energy), .link_pulse_i(link_pulse), .tx_active_o(tx_active_o),
    .pulse_type_o(pulse_type_o), .tx_pair_o(tx_pair_o), .listen_mask_o(listen_mask_o),
    .segment_o(segment_o), .peak_wait_o(peak_wait_o), .peak_span_o(peak_span_o),
    .test_busy_o(test_busy_o), .test_fail_o(test_fail_o));
  cable_echo_model i_line (.clk_i(clk_i), .arm_i(arm), .tx_active_i(tx_active_o),
    .keep_i(keep), .level_i(lvl), .pulse_i(pls), .energy_o(energy), .pulse_o(link_pulse));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Longest run is about 1,200 clocks; this leaves ample margin
  initial begin
    #3_000_000;
    err_total++;
    $display("unexpected at %0t: timeout", $time);
    finish_test();
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  // Classic cycle: hold everything until ack is sampled, then release for a cycle
  task automatic wb(input logic w, input logic [9:0] idx, input logic [15:0] d,
                    output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; wdat <= {16'h0, d}; sel <= 4'h3;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 20) chk(1'b0, 1'b1, "no ack");
  endtask

  task automatic run_test(input logic [7:0] l, input logic p, input logic k, output logic fl);
    logic [31:0] rd;
    logic        prev;
    int          n;
    lvl <= l; pls <= p; keep <= k; arm <= 1'b1;
    @(posedge clk_i);
    arm <= 1'b0;
    wb(1'b1, reflect_cfg_pkg::IDX_CONTROL, 16'h0001, rd);
    segs = '0; maxp = '0; bad = 0; txc = '{default: 0}; starts.delete(); n = 0; prev = 1'b0;
    do begin
      @(posedge clk_i);
      n++;
      if (tx_active_o === 1'b1) begin
        txc[segment_o]++;
        segs[segment_o] = 1'b1;
        if (tx_pair_o > maxp) maxp = tx_pair_o;
        if (segment_o == 3'd1 && !prev) starts.push_back(n);
        if (pulse_type_o !== ptype[segment_o] || peak_wait_o !== pwait[segment_o]) bad++;
        if (listen_mask_o !== (xd ? 4'h1 << tx_pair_o : (sk ? 4'h3 : 4'hf))) bad++;
        if (peak_span_o !== 3'd5) bad++;
      end
      prev = (tx_active_o === 1'b1) && (segment_o == 3'd1);
    end while ((test_busy_o !== 1'b0 || n < 3) && n < 4000);
    fl = test_fail_o;
    chk(n < 4000, 1'b1, "test end");
  endtask

  task automatic test_registers();
    logic [31:0] rd;
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, reflect_cfg_pkg::IDX_GENERAL_A + 10'(i), 16'h0, rd);
      chk(rd, {16'h0, rstv[i]}, "reset value");
      wb(1'b1, reflect_cfg_pkg::IDX_GENERAL_A + 10'(i), 16'hffff, rd);
      wb(1'b0, reflect_cfg_pkg::IDX_GENERAL_A + 10'(i), 16'h0, rd);
      chk(rd, {16'h0, wmv[i]}, "writable bits");
    end
    wb(1'b1, 10'h1ff, 16'hffff, rd);
    wb(1'b0, 10'h1ff, 16'h0, rd);
    chk(rd, 32'h0, "unmapped read");
    $display("test registers done");
  endtask

  task automatic test_sequence();
    logic [31:0] rd;
    logic        fl;
    ptype = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    pwait = '{4'h0, 4'h2, 4'h3, 4'h9, 4'he, 4'hf};
    wb(1'b1, reflect_cfg_pkg::IDX_LEN_LOW, 16'h50a3, rd);
    wb(1'b1, reflect_cfg_pkg::IDX_WAIT_LOW, 16'he932, rd);
    wb(1'b1, reflect_cfg_pkg::IDX_PULSE_SRCH, 16'h291f, rd);
    wb(1'b1, reflect_cfg_pkg::IDX_GENERAL_A, 16'h1c24, rd);
    sk = 1'b1; xd = 1'b1;
    run_test(8'h00, 1'b0, 1'b0, fl);
    chk(maxp, 2'd1, "pair limit");
    chk(segs, 6'b000110, "segments");
    chk(txc[1], 6, "seg one clocks");
    chk(txc[2], 10, "seg two clocks");
    chk(bad, 0, "per segment outputs");
    chk(starts.size() == 2 ? starts[1] - starts[0] : 0, 40, "cycle length");
    wb(1'b1, reflect_cfg_pkg::IDX_GENERAL_A, 16'h04bf, rd);
    sk = 1'b0; xd = 1'b0;
    run_test(8'h00, 1'b0, 1'b0, fl);
    chk(maxp, 2'd3, "all pairs");
    chk(segs, 6'b001110, "segments");
    chk(txc[1], 24, "averaged seg one");
    chk(txc[3], 4 * 2 * 20, "seg three clocks");
    chk(bad, 0, "cross listen outputs");
    chk(fl, 1'b0, "quiet line");
    wb(1'b1, reflect_cfg_pkg::IDX_GENERAL_A, 16'h1c5f, rd);
    sk = 1'b1;
    xd = 1'b1;
    run_test(8'h00, 1'b0, 1'b0, fl);
    chk(segs, 6'b111110, "five segments");
    chk(txc[4], 2 * 30, "seg four clocks");
    chk(txc[5], 2 * 160, "seg five clocks");
    chk(bad, 0, "late segment outputs");
    $display("test sequence done");
  endtask

  task automatic test_silence();
    logic [31:0] rd;
    logic        fl;
    wb(1'b1, reflect_cfg_pkg::IDX_GENERAL_A, 16'h1c24, rd);
    sk = 1'b1; xd = 1'b1;
    run_test(8'hc9, 1'b0, 1'b0, fl);
    chk(fl, 1'b1, "energy above threshold");
    run_test(8'hc8, 1'b0, 1'b0, fl);
    chk(fl, 1'b0, "energy at threshold");
    run_test(8'h00, 1'b1, 1'b0, fl);
    chk(fl, 1'b1, "link pulse checked");
    wb(1'b1, reflect_cfg_pkg::IDX_GENERAL_A, 16'h1824, rd);
    run_test(8'h00, 1'b1, 1'b0, fl);
    chk(fl, 1'b0, "link pulse ignored");
    run_test(8'h01, 1'b0, 1'b1, fl);
    chk(fl, 1'b1, "post energy");
    $display("test silence done");
  endtask

  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0; sel = '0; wdat = '0;
    arm = 1'b1; keep = 1'b0; pls = 1'b0; lvl = '0; err_total = 0; n_checks = 0;
    do_reset();
    test_registers();
    do_reset();
    test_sequence();
    test_silence();
    finish_test();
  end
endmodule
